// ### logic/byte_buffer.sv
/*
  Two-entry valid/ready buffer for bytes going into the array.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module byte_buffer
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count;
  logic [$clog2(DEPTH)-1:0]   rd;
  logic [$clog2(DEPTH)-1:0]   wr;
  logic push;
  logic pop;

  always_comb
  begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    in_ready  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
    out_valid = (count != '0);
    out_data  = slot[rd];
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      count <= '0;
      rd    <= '0;
      wr    <= '0;
    end
    else if (enable)
    begin
      if (push)
      begin
        slot[wr] <= in_data;
        wr       <= wr + 1'b1;
      end
      if (pop)
        rd <= rd + 1'b1;
      count <= count + $bits(count)'(push) - $bits(count)'(pop);
    end
  end
endmodule : byte_buffer

// ### logic/eeprom_target.sv
/*
  Two-wire serial target of a 256 x 8 memory: condition detection, addressing,
  acknowledge, page write with column wrap, self-timed programming and reads.
  Assumes the serial lines are asynchronous and are sampled by SYS_CLK.
*/
// Notes on behaviour
// - Data falling with clock high is start
// - Data rising with clock high is stop
// - Sample on clock rise, drive after fall
// - Data pin driven low only, open drain
// - Acknowledge low on ninth clock of word
// - Top address nibble must match class pattern
// - Three select bits are ignored
// - Mismatch gives no acknowledge, goes standby
// - Eighth address bit selects read or write
// - Byte write acknowledged at 9, 18, 27
// - Stop after write starts timed programming
// - Page write takes one to sixteen bytes
// - Column increments, page row stays fixed
// - Column wraps, later bytes overwrite earlier
// - No address acknowledge while programming
// - Counter holds last address plus one
// - Current read sends byte, counter increments
// - Master acknowledge requests next byte
// - Counter wraps past last location to zero
// - Dummy write loads counter for random read
// - Restart before data cancels pending write
`timescale 1ns/1ps
module eeprom_target
#(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
)
(
  input  wire logic SYS_CLK,
  input  wire logic RESET_N,
  input  wire logic CLK_EN,
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  output logic      PROGRAMMING
);
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_DEV   = 6'b00_0010,
    ST_WORD  = 6'b00_0100,
    ST_WDATA = 6'b00_1000,
    ST_RDATA = 6'b01_0000,
    ST_RACK  = 6'b10_0000
  } phase_t;

  logic       scl;
  logic       sda;
  logic       scl_d;
  logic       sda_d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  phase_t     phase;
  phase_t     next_phase;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic       ack_slot;
  logic       next_ack_slot;
  logic       got_data;
  logic       next_got_data;
  logic       pend;
  logic       next_pend;
  logic       drive_low;
  logic       next_drive_low;
  logic       prog;
  logic       next_prog;
  logic [31:0] prog_cnt;
  logic [31:0] next_prog_cnt;

  logic [7:0] mem [256];
  logic       wq_valid;
  logic       wq_ready;
  logic [15:0] wq_data;
  logic       mq_valid;
  logic       mq_ready;
  logic [15:0] mq_data;

  // ----------------------------------------
  // Line sampling
  // ----------------------------------------
  line_sync u_scl_sync (
    .clk      (SYS_CLK),
    .reset_n  (RESET_N),
    .enable   (CLK_EN),
    .line_in  (SCL_IN),
    .line_out (scl)
  );

  line_sync u_sda_sync (
    .clk      (SYS_CLK),
    .reset_n  (RESET_N),
    .enable   (CLK_EN),
    .line_in  (SDA_IN),
    .line_out (sda)
  );

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (CLK_EN)
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  always_comb
  begin
    scl_rise   = scl && !scl_d;
    scl_fall   = !scl && scl_d;
    start_seen = scl && scl_d && sda_d && !sda;
    stop_seen  = scl && scl_d && !sda_d && sda;
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_comb
  begin
    next_phase     = phase;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_addr      = addr;
    next_ack_slot  = ack_slot;
    next_got_data  = got_data;
    next_pend      = pend;
    next_drive_low = drive_low;
    next_prog      = prog;
    next_prog_cnt  = prog_cnt;
    wq_valid       = 1'b0;
    wq_data        = {addr, shift};
    if (prog)
    begin
      next_drive_low = 1'b0;
      next_phase     = ST_IDLE;
      if (prog_cnt == 32'(WRITE_CYCLES - 1))
        next_prog = 1'b0;
      else
        next_prog_cnt = prog_cnt + 32'h_0000_0001;
    end
    else if (start_seen)
    begin
      next_phase     = ST_DEV;
      next_bit_cnt   = 4'h_0;
      next_ack_slot  = 1'b0;
      next_drive_low = 1'b0;
      next_pend      = 1'b0;
      next_got_data  = 1'b0;
    end
    else if (stop_seen)
    begin
      next_phase     = ST_IDLE;
      next_drive_low = 1'b0;
      if (pend && got_data)
      begin
        next_prog     = 1'b1;
        next_prog_cnt = 32'h_0000_0000;
      end
      next_pend     = 1'b0;
      next_got_data = 1'b0;
    end
    else if (phase != ST_IDLE && scl_rise)
    begin
      if (ack_slot)
      begin
        if (phase == ST_RACK && sda)
          next_phase = ST_IDLE;
      end
      else
      begin
        next_shift   = {shift[6:0], sda};
        next_bit_cnt = bit_cnt + 4'h_1;
      end
    end
    else if (phase != ST_IDLE && scl_fall)
    begin
      next_drive_low = 1'b0;
      if (ack_slot)
      begin
        next_ack_slot = 1'b0;
        next_bit_cnt  = 4'h_0;
        if (phase == ST_RDATA || phase == ST_RACK)
        begin
          next_phase     = ST_RDATA;
          next_shift     = mem[addr];
          // first bit is the top one
          next_drive_low = !mem[addr][7];
          next_addr      = addr + 8'h_01;
        end
      end
      else if (phase == ST_RDATA)
      begin
        if (bit_cnt == 4'h_8)
        begin
          next_ack_slot = 1'b1;
          next_phase    = ST_RACK;
        end
        else
        begin
          // drive after fall
          // Each rise moves the next bit up to the top
          next_drive_low = !shift[7];
        end
      end
      else if (bit_cnt == 4'h_8)
      begin
        next_ack_slot = 1'b1;
        unique case (phase)
          ST_DEV:
          begin
            if (shift[7:4] == eeprom_pkg::CLASS_PATTERN)
            begin
              next_drive_low = 1'b1;
              next_phase     = shift[0] ? ST_RDATA : ST_WORD;
            end
            else
            begin
              next_phase    = ST_IDLE;
              next_ack_slot = 1'b0;
            end
          end
          ST_WORD:
          begin
            next_drive_low = 1'b1;
            next_addr      = shift;
            next_pend      = 1'b1;
            next_phase     = ST_WDATA;
          end
          ST_WDATA:
          begin
            next_drive_low = 1'b1;
            next_got_data  = 1'b1;
            wq_valid       = 1'b1;
            next_addr      = {addr[7:4], addr[3:0] + 4'h_1};
          end
          default:
          begin
            next_phase = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      phase     <= ST_IDLE;
      bit_cnt   <= 4'h_0;
      shift     <= 8'h_00;
      addr      <= eeprom_pkg::ADDR_RESET;
      ack_slot  <= 1'b0;
      got_data  <= 1'b0;
      pend      <= 1'b0;
      drive_low <= 1'b0;
      prog      <= 1'b0;
      prog_cnt  <= 32'h_0000_0000;
    end
    else if (CLK_EN)
    begin
      phase     <= next_phase;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      addr      <= next_addr;
      ack_slot  <= next_ack_slot;
      got_data  <= next_got_data;
      pend      <= next_pend;
      drive_low <= next_drive_low;
      prog      <= next_prog;
      prog_cnt  <= next_prog_cnt;
    end
  end

  // ----------------------------------------
  // Write path into the array
  // ----------------------------------------
  // Bytes land in the array one per cycle; serial rate keeps it from filling
  byte_buffer #(
    .WIDTH (16),
    .DEPTH (2)
  ) u_wbuf (
    .clk       (SYS_CLK),
    .reset_n   (RESET_N),
    .enable    (CLK_EN),
    .in_valid  (wq_valid),
    .in_ready  (wq_ready),
    .in_data   (wq_data),
    .out_valid (mq_valid),
    .out_ready (mq_ready),
    .out_data  (mq_data)
  );

  assign mq_ready = 1'b1;

  always_ff @(posedge SYS_CLK)
  begin
    if (CLK_EN && mq_valid)
      mem[mq_data[15:8]] <= mq_data[7:0];
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      SDA_OUT     <= 1'b0;
      SDA_OE      <= 1'b0;
      PROGRAMMING <= 1'b0;
    end
    else if (CLK_EN)
    begin
      SDA_OUT     <= 1'b0;
      SDA_OE      <= next_drive_low;
      PROGRAMMING <= next_prog;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_busy_no_ack: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    prog |-> !SDA_OE)
    else $error("data line driven during programming");

  a_drive_low_only: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    SDA_OE |-> !SDA_OUT)
    else $error("data line driven high");

  a_prog_from_stop: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(prog) |-> $past(stop_seen) && $past(got_data))
    else $error("programming began without stop after data");

  a_restart_cancel: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && start_seen && !prog) |=> !pend && phase == ST_DEV)
    else $error("start did not cancel pending write");

  a_bad_class: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && !prog && !start_seen && !stop_seen && scl_fall && phase == ST_DEV
     && !ack_slot && bit_cnt == 4'h_8 && shift[7:4] != eeprom_pkg::CLASS_PATTERN)
    |=> phase == ST_IDLE && !SDA_OE)
    else $error("mismatched address acknowledged");

  a_column_wrap: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && wq_valid) |=> addr[7:4] == $past(addr[7:4]))
    else $error("page row changed during page write");

  a_read_step: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && !prog && !start_seen && !stop_seen && !scl_rise && scl_fall
     && ack_slot && phase == ST_RDATA)
    |=> addr == $past(addr) + 8'h_01)
    else $error("read counter did not step");

  a_prog_ends: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && prog && prog_cnt == 32'(WRITE_CYCLES - 1)) |=> !prog)
    else $error("programming did not end on time");

  a_addr_ack: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && !prog && !start_seen && !stop_seen && scl_fall && phase == ST_DEV
     && !ack_slot && bit_cnt == 4'h_8 && shift[7:4] == eeprom_pkg::CLASS_PATTERN)
    |=> SDA_OE)
    else $error("matching address not acknowledged");

  a_buffer_room: assert property (
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (CLK_EN && wq_valid) |-> wq_ready)
    else $error("write byte offered to a full buffer");
endmodule : eeprom_target

// ### logic/line_sync.sv
/*
  Three-stage synchroniser for one serial line, with debounced level output.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module line_sync
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic line_in,
  output logic      line_out
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_line_out;

  // ----------------------------------------
  // Capture chain
  // ----------------------------------------
  always_comb
  begin
    next_stage    = {stage[1:0], line_in};
    // Change counts only when stages two and three agree
    next_line_out = (stage[1] == stage[2]) ? stage[2] : line_out;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage    <= 3'b111;
      line_out <= 1'b1;
    end
    else if (enable)
    begin
      stage    <= next_stage;
      line_out <= next_line_out;
    end
  end
endmodule : line_sync

// ### shared/eeprom_pkg.sv
/*
  Constants for the two-wire serial memory target: address pattern, geometry,
  programming time and synchroniser depth.
  Assumes a 40 MHz system clock that samples the serial lines.
*/
package eeprom_pkg;
  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [3:0] CLASS_PATTERN   = 4'h_A;
  localparam int         ADDR_BITS       = 8;
  localparam int         COLUMN_BITS     = 4;
  localparam int         BYTE_BITS       = 8;
  localparam logic [7:0] ADDR_RESET      = 8'h_00;
  localparam logic [7:0] BYTE_ERASED     = 8'h_FF;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CLOCK_HZ        = 40_000_000;
  localparam int         WRITE_CYCLE_MS  = 5;
  // Longest time rounds down
  localparam int         WRITE_CYCLES    = (CLOCK_HZ / 1000) * WRITE_CYCLE_MS;
  localparam int         SYNC_STAGES     = 3;
endpackage : eeprom_pkg

// ### test/bus_master_model.sv
/*
  Two-wire bus master model: START, STOP, byte send and byte receive.
  Assumes the data wire is resolved outside, with a pull-up, from sda_drv.
*/
`timescale 1ns/1ps
module bus_master_model
(
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  // Clock stands high outside frames
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // change while low
  // Period of eight clocks; target answers five clocks after the fall
  task automatic bit_cycle(input logic b, output logic r);
    scl <= 1'b0;
    tick(4);
    sda_drv <= b;
    tick(2);
    scl <= 1'b1;
    tick(1);
    r = sda_wire;
    tick(1);
  endtask : bit_cycle

  // Data moves while clock high: a condition
  task automatic cond(input logic a, input logic b);
    scl <= 1'b0;
    tick(4);
    sda_drv <= a;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_drv <= b;
    tick(6);
  endtask : cond

  task automatic start_cond();
    cond(1'b1, 1'b0);
  endtask : start_cond

  task automatic stop_cond();
    cond(1'b0, 1'b1);
  endtask : stop_cond

  // ----------------------------------------
  // Bytes
  // ----------------------------------------
  // most significant first
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_cycle(d[i], r);
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic recv_byte(input logic ack_in, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, d[i]);
    bit_cycle(~ack_in, r);
  endtask : recv_byte
endmodule : bus_master_model

// ### test/two_wire_eeprom_slave_bench.sv
/*
  Self-checking bench: writes, page wrap, polling, reads, address mismatch.
  Assumes the bus master model and a pull-up on the data wire.
*/
`timescale 1ns/1ps
module two_wire_eeprom_slave_bench;
  // Short programming time keeps the run brief
  localparam int PROG_CYCLES = 400;
  logic sys_clk     = 1'b0;
  logic reset_n     = 1'b0;
  logic clk_en      = 1'b1;
  logic scl;
  logic sda_drv;
  logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic programming;
  int   err_total    = 0;
  int   total_checks = 0;

  always #12.5 sys_clk = ~sys_clk;
  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);

  eeprom_target #(.WRITE_CYCLES(PROG_CYCLES)) u_eeprom_target
  (
    .SYS_CLK     (sys_clk),
    .RESET_N     (reset_n),
    .CLK_EN      (clk_en),
    .SCL_IN      (scl),
    .SDA_IN      (sda_wire),
    .SDA_OUT     (sda_out),
    .SDA_OE      (sda_oe),
    .PROGRAMMING (programming)
  );

  bus_master_model u_bus_master_model
  (
    .clk      (sys_clk),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  task automatic write_seq(input logic [7:0] addr, input logic [7:0] q[$]);
    logic ack;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte(8'h_AE, ack);
    check(ack, 1'b1, "address ack");
    u_bus_master_model.send_byte(addr, ack);
    check(ack, 1'b1, "word ack");
    foreach (q[i])
    begin
      u_bus_master_model.send_byte(q[i], ack);
      check(ack, 1'b1, "data ack");
    end
    u_bus_master_model.stop_cond();
    check(programming, 1'b1, "programming");
  endtask : write_seq

  task automatic read_seq(input logic dummy, input logic [7:0] addr, input logic [7:0] e[$]);
    logic       ack;
    logic [7:0] d;
    if (dummy)
    begin
      u_bus_master_model.start_cond();
      u_bus_master_model.send_byte(8'h_A4, ack);
      check(ack, 1'b1, "dummy ack");
      u_bus_master_model.send_byte(addr, ack);
      check(ack, 1'b1, "dummy word ack");
    end
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte(8'h_A1, ack);
    check(ack, 1'b1, "read ack");
    foreach (e[i])
    begin
      u_bus_master_model.recv_byte(i < e.size() - 1, d);
      check(d, e[i], "read data");
    end
    u_bus_master_model.stop_cond();
    check(programming, 1'b0, "no programming");
  endtask : read_seq

  // Bounded polling, an address-only write each time
  task automatic wait_ready();
    logic ack;
    int   n;
    ack = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 10)
    begin
      u_bus_master_model.start_cond();
      u_bus_master_model.send_byte(8'h_A0, ack);
      u_bus_master_model.stop_cond();
      n++;
    end
    check(ack, 1'b1, "poll timeout");
    if (ack !== 1'b1)
      end_of_test();
    else
      check(programming, 1'b0, "poll programs");
  endtask : wait_ready

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_byte_write();
    logic ack;
    write_seq(8'h_10, '{8'h_35});
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte(8'h_A2, ack);
    check(ack, 1'b0, "busy ack");
    u_bus_master_model.stop_cond();
    wait_ready();
    read_seq(1'b1, 8'h_10, '{8'h_35});
    $display("byte write done");
  endtask : t_byte_write

  task automatic t_page_wrap();
    logic [7:0] q[$];
    logic [7:0] e[$];
    for (int k = 0; k < 18; k++)
      q.push_back(8'h_40 + 8'(k));
    for (int c = 0; c < 15; c++)
      e.push_back(c < 14 ? 8'h_42 + 8'(c) : 8'h_50);
    write_seq(8'h_2E, q);
    wait_ready();
    read_seq(1'b1, 8'h_20, e);
    read_seq(1'b0, 8'h_00, '{8'h_51});
    $display("page wrap done");
  endtask : t_page_wrap

  task automatic t_top_wrap();
    write_seq(8'h_FF, '{8'h_C3});
    wait_ready();
    write_seq(8'h_00, '{8'h_5A});
    wait_ready();
    read_seq(1'b1, 8'h_FF, '{8'h_C3, 8'h_5A});
    $display("top wrap done");
  endtask : t_top_wrap

  task automatic t_addressing();
    logic ack;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte(8'h_B0, ack);
    check(ack, 1'b0, "foreign ack");
    u_bus_master_model.send_byte(8'h_A0, ack);
    check(ack, 1'b0, "standby ack");
    u_bus_master_model.stop_cond();
    for (int s = 0; s < 8; s++)
    begin
      u_bus_master_model.start_cond();
      u_bus_master_model.send_byte({4'h_A, 3'(s), 1'b0}, ack);
      check(ack, 1'b1, "select ack");
      u_bus_master_model.stop_cond();
      check(programming, 1'b0, "no data");
    end
    $display("addressing done");
  endtask : t_addressing

  initial
  begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_addressing();
    t_byte_write();
    t_page_wrap();
    t_top_wrap();
    end_of_test();
  end
endmodule : two_wire_eeprom_slave_bench
